// >>> logic/rfs_supervisor.sv
// rail fault supervisor: thresholds, sticky status, alert and limit response
`timescale 1ns/100ps
// Functional notes
// (RL1) a rail beyond its warning threshold sets its warning status bit and the alert
// (RL2) warning defaults: low rail 115/85 percent, high rail 108/75 percent
// (RL3) three-bit codes in low_rail_over_threshold, under_warn_threshold, high_rail_over_threshold replace the warning thresholds
// (RL4) per-fault bits in warn_response_ctrl_a and warn_response_ctrl_b override the warning response
// (RL5) response overrides count only while bit 7 of 0xb0 is one
// (RL6) a rail beyond its limit sets limit status, the alert, and stops the converter
// (RL7) per-fault bits in limit_response_ctrl_a and limit_response_ctrl_b choose hiccup or latch-off on limits
// (RL8) hiccup stops switching, keeps regulators, restarts from soft-start after 500 ms
// (RL9) latch-off stops switching, keeps regulators, waits for an enable toggle
// (RL10) converter-enable toggle soft-starts; chip-enable toggle drops regulators and reinitialises
// (RL11) limit defaults: low rail 150/40 percent, high rail 125/50 percent
// (RL12) a three-bit code in low_rail_over_threshold bits 5..3 replaces the low-rail overvoltage limit
// (RL13) the mode pin picks hiccup or latch-off unless register bits override
// (RL14) status bits are readable by the host over i2c
// (RL15) alert holds while an unmasked status bit is set; bits clear only when fault gone
module rfs_supervisor #(
  parameter int HICCUP_CYCLES = rfs_pkg::HICCUP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // digitised rail levels, percent of target
  input wire logic [7:0] low_rail_pct,
  input wire logic [7:0] high_rail_pct,
  // control pins
  input wire logic mode_latch,
  input wire logic en_pwm,
  input wire logic chip_en,
  // i2c pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // converter sequencing
  output logic main_run,
  output logic aux_on,
  output logic soft_start,
  output logic init_start,
  // alert flag
  output logic fault_alert_n
);

  typedef struct packed {
    rfs_pkg::rfs_resp_t st;
    logic [rfs_pkg::TIMER_W-1:0] timer;
    logic [7:0] ovr_en;
    logic [7:0] warn_a;
    logic [7:0] warn_b;
    logic [7:0] lim_a;
    logic [7:0] lim_b;
    logic [7:0] lo_ov_thr;
    logic [7:0] uv_thr;
    logic [7:0] hi_ov_thr;
    logic [3:0] warn;
    logic [3:0] lim;
    logic alert_n;
    logic main_run;
    logic aux_on;
    logic soft_start;
    logic init_start;
    logic en_low_seen;
    logic sda_out;
  } rfs_st_t;

  logic [1:0] rst_sync;
  logic rst_n;
  rfs_st_t s;
  rfs_st_t next_s;
  rfs_pkg::rfs_regwr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] warn_now;
  logic [3:0] lim_now;
  logic [3:0] warn_clr;
  logic [3:0] lim_clr;
  logic [3:0] go_latch;
  localparam int HICCUP_LAST = HICCUP_CYCLES - 1;

  // async assert, synchronous release
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // code 0 keeps the default, otherwise a step of two percent around it
  function automatic logic [7:0] thr(input logic [7:0] dflt, input logic [2:0] code);
    thr = (code == 3'h0) ? dflt : 8'(dflt - rfs_pkg::THR_BASE + {4'h0, code, 1'b0});
  endfunction

  // masks the alert of warnings whose response software turned off
  function automatic logic [3:0] warn_mask(input rfs_st_t r);
    warn_mask = 4'h0;
    if (r.ovr_en[rfs_pkg::OVR_EN_BIT]) begin
      warn_mask = {r.warn_b[rfs_pkg::CTL_UV_BIT], r.warn_b[rfs_pkg::CTL_OV_BIT],
                   r.warn_a[rfs_pkg::CTL_UV_BIT], r.warn_a[rfs_pkg::CTL_OV_BIT]};
    end
  endfunction

  function automatic logic [7:0] rd_mux(input rfs_st_t r, input logic [7:0] a);
    case (a)
      rfs_pkg::REG_OVR_EN: rd_mux = r.ovr_en;
      rfs_pkg::REG_WARN_CTL_A: rd_mux = r.warn_a;
      rfs_pkg::REG_WARN_CTL_B: rd_mux = r.warn_b;
      rfs_pkg::REG_LIM_CTL_A: rd_mux = r.lim_a;
      rfs_pkg::REG_LIM_CTL_B: rd_mux = r.lim_b;
      rfs_pkg::REG_LO_OV_THR: rd_mux = r.lo_ov_thr;
      rfs_pkg::REG_UV_THR: rd_mux = r.uv_thr;
      rfs_pkg::REG_HI_OV_THR: rd_mux = r.hi_ov_thr;
      rfs_pkg::REG_WARN_STAT: rd_mux = {4'h0, r.warn};
      rfs_pkg::REG_LIM_STAT: rd_mux = {4'h0, r.lim};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  rfs_i2c_target u_i2c (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .rd_data(rd_data),
    .rd_addr(rd_addr),
    .wr(wr)
  );

  assign rd_data = rd_mux(s, rd_addr); // RL14

  always_comb begin
    next_s = s;
    next_s.soft_start = 1'b0;
    next_s.init_start = 1'b0;
    // comparator decisions
    warn_now[rfs_pkg::ST_LO_OV] = low_rail_pct >
      thr(rfs_pkg::LO_OV_WARN, s.lo_ov_thr[rfs_pkg::FLD_LO_OV_WARN +: 3]); // RL2 RL3
    warn_now[rfs_pkg::ST_LO_UV] = low_rail_pct <
      thr(rfs_pkg::LO_UV_WARN, s.uv_thr[rfs_pkg::FLD_LO_UV_WARN +: 3]); // RL2 RL3
    warn_now[rfs_pkg::ST_HI_OV] = high_rail_pct >
      thr(rfs_pkg::HI_OV_WARN, s.hi_ov_thr[rfs_pkg::FLD_HI_OV_WARN +: 3]); // RL2 RL3
    warn_now[rfs_pkg::ST_HI_UV] = high_rail_pct <
      thr(rfs_pkg::HI_UV_WARN, s.uv_thr[rfs_pkg::FLD_HI_UV_WARN +: 3]); // RL2 RL3
    lim_now[rfs_pkg::ST_LO_OV] = low_rail_pct >
      thr(rfs_pkg::LO_OV_LIM, s.lo_ov_thr[rfs_pkg::FLD_LO_OV_LIM +: 3]); // RL11 RL12
    lim_now[rfs_pkg::ST_LO_UV] = low_rail_pct < rfs_pkg::LO_UV_LIM; // RL11
    lim_now[rfs_pkg::ST_HI_OV] = high_rail_pct > rfs_pkg::HI_OV_LIM; // RL11
    lim_now[rfs_pkg::ST_HI_UV] = high_rail_pct < rfs_pkg::HI_UV_LIM; // RL11
    // register writes; status takes write-one-to-clear
    warn_clr = 4'h0;
    lim_clr = 4'h0;
    if (wr.stb) begin
      case (wr.addr)
        rfs_pkg::REG_OVR_EN: next_s.ovr_en = wr.data;
        rfs_pkg::REG_WARN_CTL_A: next_s.warn_a = wr.data;
        rfs_pkg::REG_WARN_CTL_B: next_s.warn_b = wr.data;
        rfs_pkg::REG_LIM_CTL_A: next_s.lim_a = wr.data;
        rfs_pkg::REG_LIM_CTL_B: next_s.lim_b = wr.data;
        rfs_pkg::REG_LO_OV_THR: next_s.lo_ov_thr = wr.data;
        rfs_pkg::REG_UV_THR: next_s.uv_thr = wr.data;
        rfs_pkg::REG_HI_OV_THR: next_s.hi_ov_thr = wr.data;
        rfs_pkg::REG_WARN_STAT: warn_clr = wr.data[3:0];
        rfs_pkg::REG_LIM_STAT: lim_clr = wr.data[3:0];
        default: begin
        end
      endcase
    end
    // a live fault re-sets its bit, so the set wins over a clear
    next_s.warn = (s.warn & ~warn_clr) | warn_now; // RL1 RL15
    next_s.lim = (s.lim & ~lim_clr) | lim_now; // RL6 RL15
    next_s.alert_n = ~(|(next_s.warn & ~warn_mask(next_s)) | |next_s.lim); // RL1 RL4 RL5 RL6
    // per-fault latch-off choice: register bit under override, else mode pin
    go_latch = {4{mode_latch}}; // RL13
    if (s.ovr_en[rfs_pkg::OVR_EN_BIT]) begin
      go_latch = {s.lim_b[rfs_pkg::CTL_UV_BIT], s.lim_b[rfs_pkg::CTL_OV_BIT],
                  s.lim_a[rfs_pkg::CTL_UV_BIT], s.lim_a[rfs_pkg::CTL_OV_BIT]}; // RL5 RL7
    end
    case (s.st)
      rfs_pkg::RS_START: begin
        next_s.init_start = 1'b1;
        next_s.aux_on = 1'b1;
        next_s.st = rfs_pkg::RS_SOFT;
      end
      rfs_pkg::RS_SOFT: begin
        next_s.soft_start = 1'b1;
        next_s.main_run = 1'b1;
        next_s.st = rfs_pkg::RS_RUN;
      end
      rfs_pkg::RS_RUN: begin
        if (|lim_now) begin
          // latch-off wins when faults with both choices arrive together
          next_s.main_run = 1'b0; // RL6
          next_s.en_low_seen = 1'b0;
          next_s.timer = HICCUP_LAST[rfs_pkg::TIMER_W-1:0];
          next_s.st = (|(lim_now & go_latch)) ? rfs_pkg::RS_LATCH : rfs_pkg::RS_HICCUP; // RL7
        end
      end
      rfs_pkg::RS_HICCUP: begin
        // regulators stay up; only main switching pauses
        if (s.timer == '0) begin
          next_s.st = rfs_pkg::RS_SOFT; // RL8
        end else begin
          next_s.timer = s.timer - 1'b1; // RL8
        end
      end
      rfs_pkg::RS_LATCH: begin
        next_s.en_low_seen = s.en_low_seen | ~en_pwm; // RL9
        if (!chip_en) begin
          next_s.aux_on = 1'b0; // RL10
          next_s.st = rfs_pkg::RS_AUX_OFF;
        end else if (s.en_low_seen && en_pwm) begin
          next_s.st = rfs_pkg::RS_SOFT; // RL10
        end
      end
      rfs_pkg::RS_AUX_OFF: begin
        if (chip_en) begin
          next_s.st = rfs_pkg::RS_START; // RL10
        end
      end
      default: begin
        next_s.st = rfs_pkg::RS_START;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: rfs_pkg::RS_START, timer: '0, ovr_en: rfs_pkg::CTL_RESET,
             warn_a: rfs_pkg::CTL_RESET, warn_b: rfs_pkg::CTL_RESET,
             lim_a: rfs_pkg::CTL_RESET, lim_b: rfs_pkg::CTL_RESET,
             lo_ov_thr: rfs_pkg::CTL_RESET, uv_thr: rfs_pkg::CTL_RESET,
             hi_ov_thr: rfs_pkg::CTL_RESET, warn: 4'h0, lim: 4'h0, alert_n: 1'b1,
             main_run: 1'b0, aux_on: 1'b0, soft_start: 1'b0, init_start: 1'b0,
             en_low_seen: 1'b0, sda_out: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_out = s.sda_out;
  assign main_run = s.main_run;
  assign aux_on = s.aux_on;
  assign soft_start = s.soft_start;
  assign init_start = s.init_start;
  assign fault_alert_n = s.alert_n;

  a_warn_sets_bit: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL1
    low_rail_pct > rfs_pkg::LO_OV_WARN && s.lo_ov_thr[2:0] == 3'h0
    |=> s.warn[rfs_pkg::ST_LO_OV] && (!fault_alert_n || (s.ovr_en[7] && s.warn_a[0])))
    else $error("low rail overvoltage warning not flagged");

  a_warn_default_edge: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL2
    high_rail_pct == 8'h6c && s.hi_ov_thr[2:0] == 3'h0 && !s.warn[rfs_pkg::ST_HI_OV]
    && !(wr.stb && wr.addr == rfs_pkg::REG_HI_OV_THR) |=> !s.warn[rfs_pkg::ST_HI_OV])
    else $error("high rail warning raised at its own threshold");

  a_warn_thr_code: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
    s.uv_thr[5:3] == 3'h7 && high_rail_pct == 8'h50 |=> s.warn[rfs_pkg::ST_HI_UV])
    else $error("high rail undervoltage code not applied");

  a_warn_masked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL4
    s.ovr_en[7] && s.warn_a[0] && s.warn == 4'h1 && s.lim == 4'h0 |-> fault_alert_n)
    else $error("masked warning still drives the alert");

  a_override_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL5
    !s.ovr_en[7] && s.warn != 4'h0 |-> !fault_alert_n)
    else $error("warning silenced without the override enable");

  a_limit_stops: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL6
    s.st == rfs_pkg::RS_RUN && lim_now != 4'h0
    |=> !main_run && aux_on && s.lim != 4'h0 && !fault_alert_n)
    else $error("limit fault did not stop the converter");

  a_limit_choice: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL7
    s.st == rfs_pkg::RS_RUN && lim_now == 4'h1 && s.ovr_en[7] && s.lim_a[0] && !mode_latch
    |=> s.st == rfs_pkg::RS_LATCH)
    else $error("limit control bit ignored");

  a_hiccup_end: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL8
    s.st == rfs_pkg::RS_HICCUP && s.timer == '0
    |=> s.st == rfs_pkg::RS_SOFT ##1 soft_start && main_run && s.st == rfs_pkg::RS_RUN)
    else $error("hiccup did not restart by soft-start");

  a_hiccup_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL8
    s.st == rfs_pkg::RS_HICCUP && s.timer != '0 |=> s.st == rfs_pkg::RS_HICCUP && aux_on)
    else $error("hiccup ended early");

  a_latch_waits: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL9
    s.st == rfs_pkg::RS_LATCH && !s.en_low_seen && en_pwm && chip_en
    |=> s.st == rfs_pkg::RS_LATCH && !main_run && aux_on)
    else $error("latch-off left without a toggle");

  a_chip_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL10
    s.st == rfs_pkg::RS_LATCH && !chip_en |=> !aux_on ##0 s.st == rfs_pkg::RS_AUX_OFF)
    else $error("chip enable toggle kept regulators up");

  a_limit_default: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL11
    high_rail_pct == 8'h7e |=> s.lim[rfs_pkg::ST_HI_OV])
    else $error("high rail limit default missed");

  a_limit_code: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL12
    s.lo_ov_thr[5:3] == 3'h1 && low_rail_pct == 8'h91 |=> s.lim[rfs_pkg::ST_LO_OV])
    else $error("low rail limit code not applied");

  a_mode_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL13
    s.st == rfs_pkg::RS_RUN && lim_now != 4'h0 && !s.ovr_en[7]
    |=> s.st == ($past(mode_latch) ? rfs_pkg::RS_LATCH : rfs_pkg::RS_HICCUP))
    else $error("mode pin choice not followed");

  a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL14
    rd_addr == rfs_pkg::REG_LIM_STAT |-> rd_data == {4'h0, s.lim})
    else $error("limit status read mismatch");

  a_sticky_live: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL15
    s.lim[rfs_pkg::ST_HI_OV] && (high_rail_pct > rfs_pkg::HI_OV_LIM
    || !(wr.stb && wr.addr == rfs_pkg::REG_LIM_STAT)) |=> s.lim[rfs_pkg::ST_HI_OV])
    else $error("limit status dropped while live or not cleared");

endmodule // rfs_supervisor

// >>> shared/rfs_pkg.sv
// rail fault supervisor: shared constants, types and state records
package rfs_pkg;

  // register offsets (i2c command codes)
  localparam logic [7:0] REG_OVR_EN = 8'hb0;
  localparam logic [7:0] REG_WARN_CTL_A = 8'hb1;
  localparam logic [7:0] REG_WARN_CTL_B = 8'hb2;
  localparam logic [7:0] REG_LIM_CTL_A = 8'hb7;
  localparam logic [7:0] REG_LIM_CTL_B = 8'hb8;
  localparam logic [7:0] REG_LO_OV_THR = 8'hb9;
  localparam logic [7:0] REG_UV_THR = 8'hba;
  localparam logic [7:0] REG_HI_OV_THR = 8'hbb;
  localparam logic [7:0] REG_WARN_STAT = 8'hd2;
  localparam logic [7:0] REG_LIM_STAT = 8'hd7;

  // reset values of the writable registers
  localparam logic [7:0] CTL_RESET = 8'h00;

  // field positions
  localparam int OVR_EN_BIT = 7;
  localparam int ST_LO_OV = 0;
  localparam int ST_LO_UV = 1;
  localparam int ST_HI_OV = 2;
  localparam int ST_HI_UV = 3;
  localparam int CTL_OV_BIT = 0;
  localparam int CTL_UV_BIT = 1;
  localparam int FLD_LO_OV_WARN = 0;
  localparam int FLD_LO_UV_WARN = 0;
  localparam int FLD_HI_OV_WARN = 0;
  localparam int FLD_HI_UV_WARN = 3;
  localparam int FLD_LO_OV_LIM = 3;

  // default thresholds, percent of target
  localparam logic [7:0] LO_OV_WARN = 8'h73; // 115
  localparam logic [7:0] LO_UV_WARN = 8'h55; // 85
  localparam logic [7:0] HI_OV_WARN = 8'h6c; // 108
  localparam logic [7:0] HI_UV_WARN = 8'h4b; // 75
  localparam logic [7:0] LO_OV_LIM = 8'h96; // 150
  localparam logic [7:0] LO_UV_LIM = 8'h28; // 40
  localparam logic [7:0] HI_OV_LIM = 8'h7d; // 125
  localparam logic [7:0] HI_UV_LIM = 8'h32; // 50
  // nonzero threshold code: default - base + 2 * code
  localparam logic [7:0] THR_BASE = 8'h08;

  // i2c target address
  localparam logic [6:0] I2C_ADDR = 7'h40;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  // hiccup interval
  localparam int HICCUP_MS = 500;
  localparam int CLK_HZ = 10_000_000;
  localparam int HICCUP_CYCLES = HICCUP_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 23;

  typedef enum logic [2:0] {
    RS_START, RS_SOFT, RS_RUN, RS_HICCUP, RS_LATCH, RS_AUX_OFF
  } rfs_resp_t;

  typedef enum logic [3:0] {
    PH_IDLE, PH_ADDR, PH_ACK_ADDR, PH_CMD, PH_ACK_CMD, PH_WDATA, PH_ACK_W, PH_RDATA,
    PH_ACK_R
  } rfs_i2c_ph_t;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } rfs_regwr_t;

  typedef struct packed {
    rfs_i2c_ph_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic ack;
    logic oe_n;
    logic scl_q;
    logic sda_q;
    rfs_regwr_t wr;
  } rfs_i2c_st_t;

endpackage

// >>> logic/rfs_i2c_target.sv
// i2c target: one command byte, then register writes or reads at that pointer
`timescale 1ns/100ps
module rfs_i2c_target (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe_n,
  // register side
  input wire logic [7:0] rd_data,
  output logic [7:0] rd_addr,
  output rfs_pkg::rfs_regwr_t wr
);

  rfs_pkg::rfs_i2c_st_t s;
  rfs_pkg::rfs_i2c_st_t next_s;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  always_comb begin
    next_s = s;
    next_s.wr.stb = 1'b0;
    next_s.scl_q = scl;
    next_s.sda_q = sda_in;
    rise = scl & ~s.scl_q;
    fall = ~scl & s.scl_q;
    start = scl & s.scl_q & s.sda_q & ~sda_in;
    stop = scl & s.scl_q & ~s.sda_q & sda_in;
    if (start) begin
      next_s.ph = rfs_pkg::PH_ADDR;
      next_s.cnt = 4'h0;
      next_s.oe_n = 1'b1;
    end else if (stop) begin
      next_s.ph = rfs_pkg::PH_IDLE;
      next_s.oe_n = 1'b1;
    end else begin
      case (s.ph)
        rfs_pkg::PH_ADDR, rfs_pkg::PH_CMD, rfs_pkg::PH_WDATA: begin
          if (rise) begin
            next_s.sh = {s.sh[6:0], sda_in};
            next_s.cnt = s.cnt + 4'h1;
          end
          if (fall && s.cnt == rfs_pkg::I2C_BYTE_BITS) begin
            next_s.cnt = 4'h0;
            next_s.oe_n = 1'b0;
            if (s.ph == rfs_pkg::PH_ADDR) begin
              // not our address: stay off the bus until the next start
              next_s.rw = s.sh[0];
              next_s.ph = rfs_pkg::PH_ACK_ADDR;
              if (s.sh[7:1] != rfs_pkg::I2C_ADDR) begin
                next_s.oe_n = 1'b1;
                next_s.ph = rfs_pkg::PH_IDLE;
              end
            end else if (s.ph == rfs_pkg::PH_CMD) begin
              next_s.ptr = s.sh;
              next_s.ph = rfs_pkg::PH_ACK_CMD;
            end else begin
              next_s.wr.stb = 1'b1;
              next_s.wr.addr = s.ptr;
              next_s.wr.data = s.sh;
              next_s.ph = rfs_pkg::PH_ACK_W;
            end
          end
        end
        rfs_pkg::PH_ACK_ADDR: begin
          if (fall) begin
            next_s.cnt = 4'h0;
            if (s.rw) begin
              next_s.sh = rd_data;
              next_s.oe_n = rd_data[7];
              next_s.ph = rfs_pkg::PH_RDATA;
            end else begin
              next_s.oe_n = 1'b1;
              next_s.ph = rfs_pkg::PH_CMD;
            end
          end
        end
        rfs_pkg::PH_ACK_CMD, rfs_pkg::PH_ACK_W: begin
          if (fall) begin
            next_s.oe_n = 1'b1;
            next_s.cnt = 4'h0;
            next_s.ph = rfs_pkg::PH_WDATA;
          end
        end
        rfs_pkg::PH_RDATA: begin
          if (rise) begin
            next_s.cnt = s.cnt + 4'h1;
          end
          if (fall) begin
            if (s.cnt == rfs_pkg::I2C_BYTE_BITS) begin
              next_s.oe_n = 1'b1;
              next_s.ph = rfs_pkg::PH_ACK_R;
            end else begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.oe_n = s.sh[6];
            end
          end
        end
        rfs_pkg::PH_ACK_R: begin
          if (rise) begin
            next_s.ack = ~sda_in;
          end
          if (fall) begin
            // acked: resend the same register, status may have moved on
            next_s.cnt = 4'h0;
            next_s.ph = rfs_pkg::PH_IDLE;
            if (s.ack) begin
              next_s.sh = rd_data;
              next_s.oe_n = rd_data[7];
              next_s.ph = rfs_pkg::PH_RDATA;
            end
          end
        end
        default: begin
          next_s.ph = rfs_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{ph: rfs_pkg::PH_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0, ack: 1'b0,
             oe_n: 1'b1, scl_q: 1'b1, sda_q: 1'b1, wr: '0};
    end else begin
      s <= next_s;
    end
  end

  assign sda_oe_n = s.oe_n;
  assign rd_addr = s.ptr;
  assign wr = s.wr;

endmodule // rfs_i2c_target

// >>> testbench/rfs_i2c_host.sv
// i2c host model: register writes and single-byte reads
`timescale 1ns/100ps
module rfs_i2c_host (
  // clock
  input wire logic clk_sys,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_drv_n,
  // results
  output logic rd_done,
  output logic [7:0] rd_val,
  output logic nak
);
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
    rd_done = 1'b0;
    rd_val = 8'h00;
    nak = 1'b0;
  end
  // four clocks a phase keeps sda still while scl is high, so no false start or stop
  task automatic step(input logic s, input logic c);
    sda_drv_n <= s;
    scl <= c;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic bit_io(input logic b, output logic r);
    step(b, 1'b0);
    step(b, 1'b1);
    r = sda;
    step(b, 1'b0);
  endtask
  task automatic start();
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask
  // ninth bit is always released: a nack after a read byte ends the read
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
  endtask
  task automatic reg_write(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    byte_io({rfs_pkg::I2C_ADDR, 1'b0}, q, a0);
    byte_io(adr, q, a1);
    byte_io(dat, q, a2);
    stop();
    nak <= nak | a0 | a1 | a2;
  endtask
  task automatic reg_read(input logic [7:0] adr);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start();
    byte_io({rfs_pkg::I2C_ADDR, 1'b0}, q, a0);
    byte_io(adr, q, a1);
    start();
    byte_io({rfs_pkg::I2C_ADDR, 1'b1}, q, a2);
    byte_io(8'hff, q, a3);
    stop();
    nak <= nak | a0 | a1 | a2;
    rd_val <= q;
    rd_done <= 1'b1;
    @(posedge clk_sys);
    rd_done <= 1'b0;
  endtask
endmodule // rfs_i2c_host

// >>> testbench/test_rail_fault_supervisor.sv
// self-checking bench for the rail fault supervisor
`timescale 1ns/100ps
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module test_rail_fault_supervisor;
  localparam int HC = 20;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] lo = 8'h64;
  logic [7:0] hi = 8'h64;
  logic mode_latch = 1'b0;
  logic en_pwm = 1'b1;
  logic chip_en = 1'b1;
  logic scl, drv_n, sda_oe_n, sda_o, rd_done, nak;
  logic main_run, aux_on, soft_start, init_start, fault_alert_n;
  logic [7:0] rd_val, e;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  // open drain with pull-up: released means high
  wire sda = (sda_oe_n | sda_o) & drv_n;
  always #50 clk_sys = ~clk_sys;
  rfs_supervisor #(.HICCUP_CYCLES(HC)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
    .low_rail_pct(lo), .high_rail_pct(hi), .mode_latch(mode_latch), .en_pwm(en_pwm),
    .chip_en(chip_en), .scl(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n(sda_oe_n),
    .main_run(main_run), .aux_on(aux_on), .soft_start(soft_start),
    .init_start(init_start), .fault_alert_n(fault_alert_n));
  rfs_i2c_host host_u (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_drv_n(drv_n),
    .rd_done(rd_done), .rd_val(rd_val), .nak(nak));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (rd_done === 1'b1) begin
      e = exp_q.pop_front();
      `CHK(rd_val, e)
    end
    if (cyc == 40000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host_u.reg_read(a);
    cyc_n(2);
  endtask
  task automatic clr();
    host_u.reg_write(8'hd2, 8'hff);
    host_u.reg_write(8'hd7, 8'hff);
  endtask
  task automatic rails(input logic [7:0] l, input logic [7:0] h);
    @(posedge clk_sys);
    lo <= l;
    hi <= h;
    cyc_n(3);
  endtask
  initial begin
    logic [7:0] lw[4] = '{8'h74, 8'h54, 8'h64, 8'h64};
    logic [7:0] hw[4] = '{8'h64, 8'h64, 8'h6d, 8'h4a};
    void'($urandom(32'hbe35));
    lw[0] = 8'h74 + 8'($urandom % 30);
    cyc_n(20);
    rstn <= 1'b1;
    cyc_n(10);
    `CHK(aux_on, 1'b1)
    `CHK(main_run, 1'b1)
    rd(rfs_pkg::REG_LIM_CTL_A, rfs_pkg::CTL_RESET);
    rd(8'h20, 8'h00);
    rails(8'h73, 8'h6c);
    `CHK(fault_alert_n, 1'b1)
    for (i = 0; i < 4; i++) begin
      rails(lw[i], hw[i]);
      `CHK(fault_alert_n, 1'b0)
      rails(8'h64, 8'h64);
      rd(8'hd2, 8'(1 << i));
      `CHK(fault_alert_n, 1'b0)
      clr();
      rd(8'hd2, 8'h00);
      `CHK(fault_alert_n, 1'b1)
    end
    host_u.reg_write(8'hb9, 8'h01);
    rails(8'h6e, 8'h64);
    rails(8'h64, 8'h64);
    rd(8'hd2, 8'h01);
    clr();
    host_u.reg_write(8'hba, 8'h38);
    rails(8'h64, 8'h50);
    rails(8'h64, 8'h64);
    rd(8'hd2, 8'h08);
    clr();
    // mask bit written while overrides are off must not act
    host_u.reg_write(8'hb1, 8'h01);
    rails(8'h6e, 8'h64);
    `CHK(fault_alert_n, 1'b0)
    rails(8'h64, 8'h64);
    clr();
    host_u.reg_write(8'hb0, 8'h80);
    rails(8'h6e, 8'h64);
    `CHK(fault_alert_n, 1'b1)
    rails(8'h64, 8'h64);
    rd(8'hd2, 8'h01);
    clr();
    host_u.reg_write(8'hb9, 8'h08);
    rails(8'h91, 8'h64);
    `CHK(main_run, 1'b0)
    `CHK(aux_on, 1'b1)
    rails(8'h64, 8'h64);
    i = 0;
    while (main_run !== 1'b1 && i < 200) begin
      @(posedge clk_sys);
      i++;
    end
    `CHK(i inside {[HC - 10:HC]}, 1'b1)
    rd(8'hd7, 8'h01);
    clr();
    host_u.reg_write(8'hb7, 8'h01);
    rails(8'h91, 8'h64);
    rails(8'h64, 8'h64);
    cyc_n(3 * HC);
    `CHK(main_run, 1'b0)
    `CHK(aux_on, 1'b1)
    en_pwm <= 1'b0;
    cyc_n(2);
    en_pwm <= 1'b1;
    cyc_n(4);
    `CHK(main_run, 1'b1)
    clr();
    host_u.reg_write(8'hb0, 8'h00);
    mode_latch <= 1'b1;
    rails(8'h64, 8'h7e);
    `CHK(main_run, 1'b0)
    rails(8'h64, 8'h64);
    cyc_n(3 * HC);
    `CHK(main_run, 1'b0)
    chip_en <= 1'b0;
    cyc_n(2);
    `CHK(aux_on, 1'b0)
    chip_en <= 1'b1;
    cyc_n(3);
    `CHK({init_start, soft_start}, 2'b10)
    cyc_n(1);
    `CHK({init_start, soft_start}, 2'b01)
    cyc_n(2);
    `CHK({aux_on, main_run}, 2'b11)
    `CHK(nak, 1'b0)
    end_sim();
  end
endmodule // test_rail_fault_supervisor
